/* hdl/flash_self_program_pkg.sv */
package flash_self_program_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] LOCK_RESET = 8'hff;
  // ****************************************
  // control register fields
  // ****************************************
  localparam int IRQ_EN_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int RSVD_BIT = 5;
  localparam int REENABLE_BIT = 4;
  localparam int LOCK_SET_BIT = 3;
  localparam int PAGE_WRITE_BIT = 2;
  localparam int PAGE_ERASE_BIT = 1;
  localparam int STORE_EN_BIT = 0;
  localparam logic [4:0] PAT_REENABLE = 5'h11;
  localparam logic [4:0] PAT_LOCK = 5'h09;
  localparam logic [4:0] PAT_WRITE = 5'h05;
  localparam logic [4:0] PAT_ERASE = 5'h03;
  localparam logic [4:0] PAT_LOAD = 5'h01;
  // ****************************************
  // pointer layout and sections
  // ****************************************
  localparam int WORD_LSB = 1;
  localparam int WORD_BITS = 6;
  localparam int PAGE_LSB = 7;
  localparam int PAGE_BITS = 7;
  localparam int PAGE_WORDS = 64;
  localparam logic [6:0] BLOCKING_FIRST_PAGE = 7'h70;
  localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
  localparam logic [15:0] BOOT_RESET_ADDR = 16'h1c00;
  // ****************************************
  // timing
  // ****************************************
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  localparam logic [2:0] LOAD_WINDOW = 3'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_BUSY = 2'b11
  } state_t;
endpackage : flash_self_program_pkg

/* hdl/flash_self_program_control.sv */
`timescale 1ns/1ps
// Summary of operation
// - reset vector follows boot vector fuse
// - software never alters fuse values
// - ready irq while enabled, global, store clear
// - busy flag set on concurrent-section program
// - busy flag blocks concurrent-section reads
// - busy clears on re-enable or load
// - re-enable plus store enable arms window
// - re-enable ignored while programming busy
// - re-enable during loading discards buffer
// - lock store programs lock bits from data
// - lock-set bit clears on completion/timeout
// - load within three cycles reads lock/fuse
// - page write stores buffer, self-clears
// - page erase wipes page, self-clears
// - stall cpu for blocking-section programming
// - plain store fills buffer word
// - store enable open four cycles only
// - store enable stays set while busy
// - only five control patterns take effect
// - bit 5 reads zero, reset zero
// - pointer splits page/word, latched at start
// - load uses pointer bit 0 byte select
// - buffer cleared after write, re-enable, reset
module flash_self_program_control
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic store_req,
  input wire logic load_req,
  input wire logic [15:0] ptr,
  input wire logic [15:0] store_data_pair,
  input wire logic global_irq_enable,
  output logic load_special_valid,
  output logic [7:0] load_special_data,
  input wire logic flash_op_done,
  output logic flash_erase_start,
  output logic flash_write_start,
  output logic [6:0] flash_page,
  input wire logic [5:0] buf_rd_addr,
  output logic [15:0] buf_rd_data,
  input wire logic boot_vector_fuse,
  input wire logic [7:0] fuse_bits,
  output logic [15:0] reset_vector,
  output logic [7:0] lock_bits,
  output logic concurrent_section_busy,
  output logic cpu_stall,
  output logic ready_irq
);
  // ****************************************
  // declarations
  // ****************************************
  flash_self_program_pkg::state_t state_r;
  logic completion_irq_enable_r;
  logic [4:0] cmd_r;
  logic [2:0] arm_cnt_r;
  logic loading_r, op_write_r;
  logic [15:0] buf_r [flash_self_program_pkg::PAGE_WORDS];
  logic buf_clear, buf_we;
  logic [1:0] fuse_pin_r;
  logic [7:0] fuse_s1_r, fuse_s2_r;
  logic aw_got_r, w_got_r;
  logic [7:0] awaddr_r, wr_addr;
  logic [31:0] wdata_r, wr_data;
  logic [3:0] wstrb_r, wr_strb;
  logic aw_hs, w_hs, do_wr;
  logic aw_got_nxt, w_got_nxt, bvalid_nxt;
  logic ctrl_wr, cmd_valid, store_now, blocking_target;
  logic [4:0] new_cmd;
  logic [7:0] ctrl_view;

  // ****************************************
  // register bus write side
  // ****************************************
  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign do_wr = (aw_got_r | aw_hs) & (w_got_r | w_hs);
  assign wr_addr = aw_hs ? s_axi_awaddr : awaddr_r;
  assign wr_data = w_hs ? s_axi_wdata : wdata_r;
  assign wr_strb = w_hs ? s_axi_wstrb : wstrb_r;
  assign aw_got_nxt = (aw_got_r | aw_hs) & ~do_wr;
  assign w_got_nxt = (w_got_r | w_hs) & ~do_wr;
  assign bvalid_nxt = do_wr | (s_axi_bvalid & ~s_axi_bready);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= flash_self_program_pkg::RESP_OKAY;
    end
    else
    begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      if (aw_hs)
        awaddr_r <= s_axi_awaddr;
      if (w_hs)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      // one write at a time: ready drops while the response is pending
      s_axi_awready <= ~aw_got_nxt & ~bvalid_nxt;
      s_axi_wready <= ~w_got_nxt & ~bvalid_nxt;
      s_axi_bvalid <= bvalid_nxt;
      if (do_wr)
      begin
        if (wr_addr == flash_self_program_pkg::CTRL_OFFSET)
          s_axi_bresp <= flash_self_program_pkg::RESP_OKAY;
        else if (wr_addr == flash_self_program_pkg::STATUS_OFFSET)
          s_axi_bresp <= flash_self_program_pkg::RESP_OKAY;
        else
          s_axi_bresp <= flash_self_program_pkg::RESP_SLVERR;
      end
    end
  end

  // ****************************************
  // register bus read side
  // ****************************************
  assign ctrl_view = {completion_irq_enable_r, concurrent_section_busy, 1'b0, cmd_r};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= flash_self_program_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == flash_self_program_pkg::CTRL_OFFSET)
      begin
        s_axi_rdata <= {24'h000000, ctrl_view};
        s_axi_rresp <= flash_self_program_pkg::RESP_OKAY;
      end
      else if (s_axi_araddr == flash_self_program_pkg::STATUS_OFFSET)
      begin
        s_axi_rdata <= {reset_vector, fuse_s2_r, lock_bits};
        s_axi_rresp <= flash_self_program_pkg::RESP_OKAY;
      end
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= flash_self_program_pkg::RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
    else
      s_axi_arready <= 1'b1;
  end

  // ****************************************
  // command decode
  // ****************************************
  assign ctrl_wr = do_wr && wr_addr == flash_self_program_pkg::CTRL_OFFSET && wr_strb[0];
  assign new_cmd = wr_data[4:0];
  assign cmd_valid = new_cmd == flash_self_program_pkg::PAT_REENABLE
                  || new_cmd == flash_self_program_pkg::PAT_LOCK
                  || new_cmd == flash_self_program_pkg::PAT_WRITE
                  || new_cmd == flash_self_program_pkg::PAT_ERASE
                  || new_cmd == flash_self_program_pkg::PAT_LOAD;
  assign store_now = state_r == flash_self_program_pkg::ST_ARMED && store_req;
  assign blocking_target = ptr[13:7] >= flash_self_program_pkg::BLOCKING_FIRST_PAGE;

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= flash_self_program_pkg::ST_IDLE;
      completion_irq_enable_r <= flash_self_program_pkg::CTRL_RESET[7];
      cmd_r <= flash_self_program_pkg::CTRL_RESET[4:0];
      arm_cnt_r <= 3'h0;
      op_write_r <= 1'b0;
      flash_page <= 7'h00;
      flash_erase_start <= 1'b0;
      flash_write_start <= 1'b0;
      lock_bits <= flash_self_program_pkg::LOCK_RESET;
    end
    else
    begin
      flash_erase_start <= 1'b0;
      flash_write_start <= 1'b0;
      if (ctrl_wr)
        completion_irq_enable_r <= wr_data[flash_self_program_pkg::IRQ_EN_BIT];
      case (state_r)
        flash_self_program_pkg::ST_IDLE,
        flash_self_program_pkg::ST_ARMED:
        begin
          if (store_now)
          begin
            // the page is latched here so the pointer is free afterwards
            if (cmd_r == flash_self_program_pkg::PAT_ERASE || cmd_r == flash_self_program_pkg::PAT_WRITE)
            begin
              flash_page <= ptr[13:7];
              op_write_r <= cmd_r == flash_self_program_pkg::PAT_WRITE;
              flash_write_start <= cmd_r == flash_self_program_pkg::PAT_WRITE;
              flash_erase_start <= cmd_r == flash_self_program_pkg::PAT_ERASE;
              state_r <= flash_self_program_pkg::ST_BUSY;
            end
            else
            begin
              if (cmd_r == flash_self_program_pkg::PAT_LOCK)
                lock_bits <= lock_bits & store_data_pair[7:0];
              cmd_r <= 5'h00;
              state_r <= flash_self_program_pkg::ST_IDLE;
            end
          end
          else if (ctrl_wr && cmd_valid)
          begin
            cmd_r <= new_cmd;
            arm_cnt_r <= 3'h0;
            state_r <= flash_self_program_pkg::ST_ARMED;
          end
          else if (state_r == flash_self_program_pkg::ST_ARMED)
          begin
            // window closes after four idle cycles
            if (arm_cnt_r == flash_self_program_pkg::STORE_WINDOW - 3'h1)
            begin
              cmd_r <= 5'h00;
              state_r <= flash_self_program_pkg::ST_IDLE;
            end
            else
              arm_cnt_r <= arm_cnt_r + 3'h1;
          end
        end
        flash_self_program_pkg::ST_BUSY:
        begin
          // control writes other than the irq enable are dropped here
          if (flash_op_done)
          begin
            cmd_r <= 5'h00;
            state_r <= flash_self_program_pkg::ST_IDLE;
          end
        end
        default:
          state_r <= flash_self_program_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // section busy, stall and ready request
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      concurrent_section_busy <= 1'b0;
      cpu_stall <= 1'b0;
      ready_irq <= 1'b0;
    end
    else
    begin
      // the block output gates every fetch and read of the concurrent section
      if (store_now && (cmd_r == flash_self_program_pkg::PAT_ERASE || cmd_r == flash_self_program_pkg::PAT_WRITE))
      begin
        if (!blocking_target)
          concurrent_section_busy <= 1'b1;
      end
      else if (store_now && (cmd_r == flash_self_program_pkg::PAT_REENABLE || cmd_r == flash_self_program_pkg::PAT_LOAD))
        concurrent_section_busy <= 1'b0;
      if (store_now && blocking_target
          && (cmd_r == flash_self_program_pkg::PAT_ERASE || cmd_r == flash_self_program_pkg::PAT_WRITE))
        cpu_stall <= 1'b1;
      else if (state_r == flash_self_program_pkg::ST_BUSY && flash_op_done)
        cpu_stall <= 1'b0;
      ready_irq <= completion_irq_enable_r & global_irq_enable & ~cmd_r[0];
    end
  end

  // ****************************************
  // temporary page buffer
  // ****************************************
  assign buf_we = store_now && cmd_r == flash_self_program_pkg::PAT_LOAD;
  // clearing by re-enable happens at once if a load is under way, else at its store
  assign buf_clear = (store_now && cmd_r == flash_self_program_pkg::PAT_REENABLE)
                  || (ctrl_wr && new_cmd == flash_self_program_pkg::PAT_REENABLE && loading_r
                      && state_r != flash_self_program_pkg::ST_BUSY)
                  || (state_r == flash_self_program_pkg::ST_BUSY && flash_op_done && op_write_r);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      loading_r <= 1'b0;
    else if (buf_clear)
      loading_r <= 1'b0;
    else if (buf_we)
      loading_r <= 1'b1;
  end

  // one entry per word; reset clears them all
  for (genvar i = 0; i < flash_self_program_pkg::PAGE_WORDS; i++)
  begin : g_buf
    always_ff @(posedge aclk)
    begin
      if (!aresetn || buf_clear)
        buf_r[i] <= 16'hffff;
      else if (buf_we && ptr[6:1] == 6'(i))
        buf_r[i] <= store_data_pair;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      buf_rd_data <= 16'h0000;
    else
      buf_rd_data <= buf_r[buf_rd_addr];
  end

  // ****************************************
  // lock and fuse readback
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      load_special_valid <= 1'b0;
      load_special_data <= 8'h00;
    end
    else
    begin
      load_special_valid <= 1'b0;
      if (load_req && state_r == flash_self_program_pkg::ST_ARMED
          && cmd_r == flash_self_program_pkg::PAT_LOCK
          && arm_cnt_r < flash_self_program_pkg::LOAD_WINDOW)
      begin
        load_special_valid <= 1'b1;
        load_special_data <= ptr[0] ? lock_bits : fuse_s2_r;
      end
    end
  end

  // ****************************************
  // fuses and reset vector
  // ****************************************
  // fuses are inputs only; the bus reads them through status but no bus path writes them
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fuse_pin_r <= 2'h3;
      fuse_s1_r <= 8'hff;
      fuse_s2_r <= 8'hff;
      reset_vector <= flash_self_program_pkg::APP_RESET_ADDR;
    end
    else
    begin
      fuse_pin_r <= {fuse_pin_r[0], boot_vector_fuse};
      fuse_s1_r <= fuse_bits;
      fuse_s2_r <= fuse_s1_r;
      reset_vector <= fuse_pin_r[1] ? flash_self_program_pkg::APP_RESET_ADDR
                                    : flash_self_program_pkg::BOOT_RESET_ADDR;
    end
  end

endmodule : flash_self_program_control

/* verif/flash_self_program_checker.sv */
`timescale 1ns/1ps
module flash_self_program_checker
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic global_irq_enable,
  input wire logic load_req,
  input wire logic load_special_valid,
  input wire logic flash_op_done,
  input wire logic flash_erase_start,
  input wire logic flash_write_start,
  input wire logic [6:0] flash_page,
  input wire logic boot_vector_fuse,
  input wire logic [15:0] reset_vector,
  input wire logic [7:0] lock_bits,
  input wire logic concurrent_section_busy,
  input wire logic cpu_stall,
  input wire logic ready_irq
);
  // ****
  // port relations
  // ****
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire strt = flash_erase_start || flash_write_start;
  irq_global_a: assert property (ready_irq |-> $past(global_irq_enable))
    else $error("ready irq without global enable");
  irq_quiet_a: assert property (cpu_stall |-> !ready_irq)
    else $error("ready irq while programming");
  stall_start_a: assert property ($rose(cpu_stall) |-> strt && flash_page >= flash_self_program_pkg::BLOCKING_FIRST_PAGE)
    else $error("stall without blocking start");
  stall_hold_a: assert property (cpu_stall |=> cpu_stall == !$past(flash_op_done))
    else $error("stall not held to completion");
  busy_set_a: assert property (strt && flash_page < flash_self_program_pkg::BLOCKING_FIRST_PAGE |-> concurrent_section_busy && !cpu_stall)
    else $error("busy flag missing on concurrent start");
  start_pulse_a: assert property (strt |-> !(flash_erase_start && flash_write_start) ##1 !strt)
    else $error("start pulse malformed");
  load_reply_a: assert property (load_special_valid |-> $past(load_req))
    else $error("special load answer without request");
  lock_clear_a: assert property ($past(aresetn) |-> (lock_bits & ~$past(lock_bits)) == 8'h00)
    else $error("lock bit returned to one");
  vec_app_a: assert property (boot_vector_fuse [*4] |-> reset_vector == flash_self_program_pkg::APP_RESET_ADDR)
    else $error("reset vector not application start");
  vec_boot_a: assert property ((!boot_vector_fuse) [*4] |-> reset_vector == flash_self_program_pkg::BOOT_RESET_ADDR)
    else $error("reset vector not boot start");
endmodule : flash_self_program_checker
bind flash_self_program_control flash_self_program_checker i_chk (.*);

/* verif/flash_array_model.sv */
`timescale 1ns/1ps
module flash_array_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic erase_go,
  input wire logic write_go,
  input wire logic [7:0] op_delay,
  output logic op_done
);
  // ****
  // array timer
  // ****
  // a restart while busy reloads the count; the block never issues one
  logic busy_r;
  logic [7:0] cnt_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_r <= 1'b0;
      cnt_r <= 8'h00;
      op_done <= 1'b0;
    end
    else
    begin
      op_done <= busy_r && cnt_r == 8'h00;
      if (erase_go || write_go)
      begin
        busy_r <= 1'b1;
        cnt_r <= op_delay;
      end
      else if (busy_r)
      begin
        busy_r <= cnt_r != 8'h00;
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule : flash_array_model

/* verif/flash_self_program_control_bench.sv */
`timescale 1ns/1ps
module flash_self_program_control_bench;
  // ****
  // signals
  // ****
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, fuse_bits = 8'h5a, op_delay = 8'h02;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic store_req = 1'b0, load_req = 1'b0, global_irq_enable = 1'b0, boot_vector_fuse = 1'b1;
  logic [15:0] ptr = 16'h0, store_data_pair = 16'h0, buf_rd_data, reset_vector;
  logic [5:0] buf_rd_addr = 6'h0;
  logic [7:0] load_special_data, lock_bits;
  logic [6:0] flash_page;
  logic load_special_valid, flash_op_done, flash_erase_start, flash_write_start;
  logic concurrent_section_busy, cpu_stall, ready_irq;
  int fails = 0, checks = 0, cycles = 0;
  always #20 aclk = ~aclk;
  flash_self_program_control i_dut (.*);
  flash_array_model i_flash (.aclk(aclk), .aresetn(aresetn), .erase_go(flash_erase_start),
    .write_go(flash_write_start), .op_delay(op_delay), .op_done(flash_op_done));
  // ****
  // helpers
  // ****
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr
  task automatic ck_ctrl(input logic [7:0] e);
    rdr(8'h00);
    cmp("ctrl", {24'h0, e}, rd);
  endtask : ck_ctrl
  // one-cycle instruction pulse; outputs are looked at once its edge has landed
  task automatic instr(input logic is_load, input logic [15:0] p, input logic [15:0] d);
    @(posedge aclk);
    store_req <= !is_load;
    load_req <= is_load;
    ptr <= p;
    store_data_pair <= d;
    @(posedge aclk);
    store_req <= 1'b0;
    load_req <= 1'b0;
    #1;
  endtask : instr
  task automatic ck_buf(input logic [5:0] a, input logic [15:0] e);
    @(posedge aclk);
    buf_rd_addr <= a;
    @(posedge aclk);
    #1;
    cmp("buffer word", {16'h0, e}, {16'h0, buf_rd_data});
  endtask : ck_buf
  task automatic wait_op;
    while (flash_op_done !== 1'b1) @(posedge aclk);
    @(posedge aclk);
    #1;
  endtask : wait_op
  // ****
  // scenarios
  // ****
  task automatic t_regs;
    rdr(8'h08);
    cmp("unmapped resp", 32'h2, {30'h0, rsp});
    wr(8'h0c, 32'h81);
    cmp("unmapped bresp", 32'h2, {30'h0, rsp});
    ck_ctrl(8'h00);
    wr(8'h04, 32'h0);
    cmp("status bresp", 32'h0, {30'h0, rsp});
    rdr(8'h04);
    cmp("status", 32'h00005aff, rd);
    boot_vector_fuse <= 1'b0;
    repeat (4) @(posedge aclk);
    rdr(8'h04);
    cmp("status boot", {flash_self_program_pkg::BOOT_RESET_ADDR, 16'h5aff}, rd);
    boot_vector_fuse <= 1'b1;
    wr(8'h00, 32'hff);
    ck_ctrl(8'h80);
    wr(8'h00, 32'h07);
    ck_ctrl(8'h00);
    wr(8'h00, 32'h80);
    global_irq_enable <= 1'b1;
    repeat (3) @(posedge aclk);
    cmp("ready irq", 32'h1, {31'h0, ready_irq});
    wr(8'h00, 32'h81);
    repeat (2) @(posedge aclk);
    cmp("ready irq armed", 32'h0, {31'h0, ready_irq});
    global_irq_enable <= 1'b0;
    wr(8'h00, 32'h00);
  endtask : t_regs
  task automatic t_load;
    wr(8'h00, 32'h01);
    instr(1'b0, {2'b00, 7'h05, 6'h09, 1'b1}, 16'hbeef);
    ck_buf(6'h09, 16'hbeef);
    ck_ctrl(8'h00);
    wr(8'h00, 32'h01);
    @(posedge aclk);
    instr(1'b0, 16'h0016, 16'h2222);
    ck_buf(6'h0b, 16'h2222);
    wr(8'h00, 32'h01);
    repeat (5) @(posedge aclk);
    instr(1'b0, 16'h0014, 16'h1111);
    ck_buf(6'h0a, 16'hffff);
  endtask : t_load
  // slow array so the ctrl accesses land inside the erase
  task automatic t_erase;
    op_delay <= 8'd20;
    wr(8'h00, 32'h03);
    instr(1'b0, {2'b00, 7'h03, 7'h7f}, 16'h0);
    cmp("erase start", 32'h1, {31'h0, flash_erase_start});
    cmp("page", 32'h3, {25'h0, flash_page});
    cmp("busy stall", 32'h2, {30'h0, concurrent_section_busy, cpu_stall});
    ck_ctrl(8'h43);
    wr(8'h00, 32'h11);
    ck_ctrl(8'h43);
    wait_op;
    ck_ctrl(8'h40);
    wr(8'h00, 32'h11);
    instr(1'b0, 16'hffff, 16'h0);
    ck_ctrl(8'h00);
    ck_buf(6'h09, 16'hffff);
  endtask : t_erase
  task automatic t_write;
    op_delay <= 8'd2;
    wr(8'h00, 32'h03);
    instr(1'b0, 16'h0200, 16'h0);
    wait_op;
    wr(8'h00, 32'h01);
    instr(1'b0, 16'h0006, 16'h5555);
    cmp("busy", 32'h0, {31'h0, concurrent_section_busy});
    wr(8'h00, 32'h05);
    instr(1'b0, {2'b00, 7'h71, 7'h00}, 16'h0);
    cmp("write start", 32'h1, {31'h0, flash_write_start});
    cmp("busy stall", 32'h1, {30'h0, concurrent_section_busy, cpu_stall});
    wait_op;
    cmp("stall end", 32'h0, {31'h0, cpu_stall});
    ck_ctrl(8'h00);
    ck_buf(6'h03, 16'hffff);
  endtask : t_write
  task automatic t_abort;
    wr(8'h00, 32'h01);
    instr(1'b0, 16'h0004, 16'h0abc);
    ck_buf(6'h02, 16'h0abc);
    wr(8'h00, 32'h11);
    ck_buf(6'h02, 16'hffff);
  endtask : t_abort
  task automatic t_lock;
    wr(8'h00, 32'h09);
    instr(1'b1, 16'h0001, 16'h0);
    cmp("lock read", 32'h1ff, {23'h0, load_special_valid, load_special_data});
    wr(8'h00, 32'h09);
    instr(1'b1, 16'h0000, 16'h0);
    cmp("fuse read", 32'h15a, {23'h0, load_special_valid, load_special_data});
    wr(8'h00, 32'h09);
    @(posedge aclk);
    instr(1'b1, 16'h0001, 16'h0);
    cmp("late load", 32'h0, {31'h0, load_special_valid});
    repeat (4) @(posedge aclk);
    ck_ctrl(8'h00);
    wr(8'h00, 32'h09);
    instr(1'b0, 16'hffff, 16'h00f0);
    cmp("lock bits", 32'hf0, {24'h0, lock_bits});
    ck_ctrl(8'h00);
  endtask : t_lock
  // ****
  // run control
  // ****
  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      final_report;
    end
  end
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_load;
    t_erase;
    t_write;
    t_abort;
    t_lock;
    final_report;
  end
endmodule : flash_self_program_control_bench
